// [common/pd_pkg.sv]
// Purpose: Shared constants and types for the powered-device sleep and flag control.
// Assumes: 20 MHz MCLK; analog comparators are delivered as digital levels.
// Notes: Times are kept in ns; cycle counts derive from the clock period.
// Contract
// - Adapter sensing is armed only after input passes the mark threshold.
// - Adapter sense above 9V turns the switch off and enables the flag sink.
// - Supply-ok sink (230uA) is on while the isolation switch turns on.
// - Supply-ok sink is off in detection, classification and steady power mode.
// - Supply-ok sink is on whenever the device sleeps.
// - Flag sink (1.5mA) is on when Type 2 source or adapter is detected.
// - Type 2 flag sink follows full switch-on, holds until undervoltage turn-off.
// - Type 2 detection is latched, cleared only below the flag reset level.
// - Adapter-driven flag is not latched; it follows adapter sense directly.
// - Flag sink is forced off throughout sleep.
// - Indicator output pulses only during sleep.
// - Falling edge on sleep request puts the device into sleep.
// - Falling edge on wake request returns the device to wake operation.
// - Deep sleep chosen when select is low at the sleep request edge.
// - Deep sleep draws less current yet keeps the maintain-power signature.
// - Isolation switch stays on while sleep holds the supply-ok sink.
// - Sleep pulses run at 25 percent duty, 250 Hz or 15.625 kHz.
// - Deep sleep signature current: on 84 ms, off 228 ms, repeating.
// - Power mode above 35.4V; switch off after below 31V longer than delay.
package pd_pkg;

  localparam int CNT_W = 23;
  localparam int IN_W = 10;

  // Synchronised input slots
  localparam int IN_ABOVE_ON = 0;
  localparam int IN_BELOW_OFF = 1;
  localparam int IN_BELOW_RESET = 2;
  localparam int IN_ABOVE_MARK = 3;
  localparam int IN_ADAPTER = 4;
  localparam int IN_FULLY_ON = 5;
  localparam int IN_TYPE2 = 6;
  localparam int IN_SLEEP_N = 7;
  localparam int IN_WAKE_N = 8;
  localparam int IN_DEEP_N = 9;
  // Active-low requests idle high (pull-ups)
  localparam logic [IN_W-1:0] SYNC_RESET = 10'h380;

  // Register map, byte addresses
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam int CTRL_FAST_BIT = 0;
  localparam logic CTRL_FAST_RESET = 1'h0;
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_DEEP_BIT = 2;
  localparam int STATUS_TYPE2_BIT = 3;
  localparam int STATUS_ARMED_BIT = 4;
  localparam int STATUS_ADAPTER_BIT = 5;
  localparam int STATUS_SIG_BIT = 6;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLOW_PERIOD_NS = 4_000_000;
  localparam int FAST_PERIOD_NS = 64_000;
  localparam int SIG_ON_NS = 84_000_000;
  localparam int SIG_OFF_NS = 228_000_000;
  localparam int OFF_DELAY_NS = 1_000_000;
  localparam int SLOW_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FAST_CYCLES = FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SIG_ON_CYCLES = SIG_ON_NS / CLK_PERIOD_NS;
  localparam int SIG_OFF_CYCLES = SIG_OFF_NS / CLK_PERIOD_NS;
  localparam int OFF_DELAY_CYCLES = OFF_DELAY_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_OFF, ST_INRUSH, ST_POWER, ST_SLEEP} mode_t;

endpackage : pd_pkg

// [dv/pse_model.sv]
// Purpose: Power source and switch model feeding the comparator levels.
// Assumes: stage 0 below flag reset, 1 above mark but below off, 2 above turn-on.
// Notes: Switch reports fully on only after a short ramp, like a real inrush.
`timescale 1ns/1ns
module pse_model #(
  parameter int RAMP_CYCLES = 5
) (
  input wire logic MCLK,
  input wire logic [1:0] stage,
  input wire logic two_event,
  input wire logic switch_drive,
  output logic above_on,
  output logic below_off,
  output logic below_reset,
  output logic above_mark,
  output logic type2_seen,
  output logic fully_on
);
  int ramp;
  initial begin
    ramp = 0;
    above_on = 1'b0;
    below_off = 1'b1;
    below_reset = 1'b1;
    above_mark = 1'b0;
    type2_seen = 1'b0;
    fully_on = 1'b0;
  end
  // Levels follow the applied voltage
  always @(posedge MCLK) begin
    above_on <= (stage == 2'h2);
    below_off <= (stage != 2'h2);
    below_reset <= (stage == 2'h0);
    above_mark <= (stage != 2'h0);
    type2_seen <= two_event && (stage != 2'h0);
    ramp <= switch_drive ? ((ramp < RAMP_CYCLES) ? ramp + 1 : ramp) : 0;
    // Feedback drops as soon as drive goes, so no stale fully-on is seen
    fully_on <= switch_drive && (ramp == RAMP_CYCLES);
  end
endmodule : pse_model

// [dv/tb_pd_sleep_flag_control.sv]
// Purpose: Self-checking bench for the sleep, flag and supply-ok control.
// Assumes: Shortened counts: pulse 16/8, signature 20/40, off delay 10 cycles.
// Notes: Outputs are grouped as switch, supply-ok, flag, deep sleep.
`timescale 1ns/1ns
module tb_pd_sleep_flag_control;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic ADAPTER_SENSE_IN = 1'b0;
  logic SLEEP_REQUEST_N = 1'b1;
  logic WAKE_REQUEST_N = 1'b1;
  logic DEEP_SLEEP_SELECT_N = 1'b1;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, SWITCH_ON, SUPPLY_OK_SINK, TYPE2_FLAG_SINK;
  logic INDICATOR_PULSE_OUT, SIGNATURE_CURRENT_EN, DEEP_SLEEP_ACTIVE;
  logic VIN_ABOVE_ON, VIN_BELOW_OFF, VIN_BELOW_RESET, VIN_ABOVE_MARK, TYPE2_SEEN;
  logic SWITCH_FULLY_ON;
  logic [1:0] stage = 2'h0;
  logic two_event = 1'b0;
  logic [31:0] rd;
  int k;
  int n_errors = 0;
  int num_checks = 0;
  always #25 MCLK = ~MCLK;
  pse_model i_pse (.MCLK(MCLK), .stage(stage), .two_event(two_event),
    .switch_drive(SWITCH_ON), .above_on(VIN_ABOVE_ON), .below_off(VIN_BELOW_OFF),
    .below_reset(VIN_BELOW_RESET), .above_mark(VIN_ABOVE_MARK),
    .type2_seen(TYPE2_SEEN), .fully_on(SWITCH_FULLY_ON));
  pd_sleep_flag_control #(.SLOW_CYCLES(16), .FAST_CYCLES(8), .SIG_ON_CYCLES(20),
    .SIG_OFF_CYCLES(40), .OFF_DELAY_CYCLES(10)) i_dut (.MCLK(MCLK), .RST_N(RST_N),
    .VIN_ABOVE_ON(VIN_ABOVE_ON), .VIN_BELOW_OFF(VIN_BELOW_OFF),
    .VIN_BELOW_RESET(VIN_BELOW_RESET), .VIN_ABOVE_MARK(VIN_ABOVE_MARK),
    .ADAPTER_SENSE_IN(ADAPTER_SENSE_IN), .SWITCH_FULLY_ON(SWITCH_FULLY_ON),
    .TYPE2_SEEN(TYPE2_SEEN), .SLEEP_REQUEST_N(SLEEP_REQUEST_N),
    .WAKE_REQUEST_N(WAKE_REQUEST_N), .DEEP_SLEEP_SELECT_N(DEEP_SLEEP_SELECT_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SWITCH_ON(SWITCH_ON),
    .SUPPLY_OK_SINK(SUPPLY_OK_SINK), .TYPE2_FLAG_SINK(TYPE2_FLAG_SINK),
    .INDICATOR_PULSE_OUT(INDICATOR_PULSE_OUT),
    .SIGNATURE_CURRENT_EN(SIGNATURE_CURRENT_EN), .DEEP_SLEEP_ACTIVE(DEEP_SLEEP_ACTIVE));
  function automatic logic [3:0] outs();
    return {SWITCH_ON, SUPPLY_OK_SINK, TYPE2_FLAG_SINK, DEEP_SLEEP_ACTIVE};
  endfunction : outs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task automatic give_up(input string what);
    n_errors++;
    $display("unexpected at %0t: %s never came", $time, what);
    summarize();
  endtask : give_up
  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
    int i;
    @(posedge MCLK);
    AVS_ADDRESS <= addr;
    AVS_WRITEDATA <= wdata;
    AVS_READ <= ~wr;
    AVS_WRITE <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge MCLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (i == 20) give_up("bus answer");
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  // Pins pass a synchroniser, so the mode change is polled with a bound
  task automatic expect_outs(input logic [3:0] mask, input logic [3:0] exp, input string what);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge MCLK);
      if ((outs() & mask) === exp) break;
    end
    if (i == 40) give_up(what);
    check({28'h000_0000, outs() & mask}, {28'h000_0000, exp}, what);
  endtask : expect_outs
  task automatic count_high(input logic sel, input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge MCLK);
      if ((sel ? SIGNATURE_CURRENT_EN : INDICATOR_PULSE_OUT) === 1'b1) cnt++;
    end
  endtask : count_high
  task automatic request(input logic s, input logic w);
    @(posedge MCLK);
    SLEEP_REQUEST_N <= ~s;
    WAKE_REQUEST_N <= ~w;
    repeat (4) @(posedge MCLK);
    SLEEP_REQUEST_N <= 1'b1;
    WAKE_REQUEST_N <= 1'b1;
  endtask : request
  task automatic status_mode(input logic [1:0] exp);
    bus(1'b0, pd_pkg::STATUS_ADDR, 32'h0000_0000);
    check({30'h0, rd[1:0]}, {30'h0, exp}, "status mode");
  endtask : status_mode
  initial begin
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    bus(1'b0, pd_pkg::CTRL_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_0000, "ctrl reset");
    bus(1'b1, 4'h8, 32'h0000_00FF);
    bus(1'b0, 4'h8, 32'h0000_0000);
    check(rd, 32'h0000_0000, "unmapped read");
    // Lane 0 disabled: the rate bit must not move
    AVS_BYTEENABLE <= 4'h0;
    bus(1'b1, pd_pkg::CTRL_ADDR, 32'h0000_0001);
    AVS_BYTEENABLE <= 4'hF;
    bus(1'b0, pd_pkg::CTRL_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_0000, "masked ctrl write");
    ADAPTER_SENSE_IN <= 1'b1;
    repeat (8) @(posedge MCLK);
    check({31'h0, TYPE2_FLAG_SINK}, 32'h0000_0000, "adapter unarmed");
    ADAPTER_SENSE_IN <= 1'b0;
    $display("test arming done");
    two_event <= 1'b1;
    stage <= 2'h2;
    expect_outs(4'hC, 4'hC, "inrush");
    expect_outs(4'hF, 4'hA, "power");
    status_mode(pd_pkg::ST_POWER);
    $display("test power up done");
    request(1'b1, 1'b0);
    expect_outs(4'hF, 4'hC, "sleep");
    count_high(1'b0, 32, k);
    check(k, 32'd8, "slow pulse duty");
    bus(1'b1, pd_pkg::CTRL_ADDR, 32'h0000_0001);
    bus(1'b0, pd_pkg::CTRL_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_0001, "ctrl fast rate");
    repeat (16) @(posedge MCLK);
    count_high(1'b0, 16, k);
    check(k, 32'd4, "fast pulse duty");
    count_high(1'b1, 20, k);
    check(k, 32'd20, "sleep signature");
    status_mode(pd_pkg::ST_SLEEP);
    request(1'b0, 1'b1);
    expect_outs(4'hF, 4'hA, "wake");
    count_high(1'b0, 16, k);
    check(k, 32'd0, "no pulse awake");
    request(1'b1, 1'b1);
    repeat (8) @(posedge MCLK);
    check({28'h000_0000, outs()}, 32'h0000_000A, "coincident edges");
    $display("test sleep and wake done");
    DEEP_SLEEP_SELECT_N <= 1'b0;
    request(1'b1, 1'b0);
    expect_outs(4'hF, 4'hD, "deep sleep");
    count_high(1'b1, 60, k);
    check(k, 32'd20, "deep signature duty");
    request(1'b0, 1'b1);
    DEEP_SLEEP_SELECT_N <= 1'b1;
    expect_outs(4'hF, 4'hA, "deep wake");
    $display("test deep sleep done");
    stage <= 2'h1;
    repeat (6) @(posedge MCLK);
    check({31'h0, SWITCH_ON}, 32'h0000_0001, "off delay hold");
    expect_outs(4'hF, 4'h0, "undervoltage off");
    stage <= 2'h0;
    two_event <= 1'b0;
    repeat (8) @(posedge MCLK);
    stage <= 2'h2;
    expect_outs(4'hF, 4'h8, "latch cleared");
    $display("test undervoltage done");
    ADAPTER_SENSE_IN <= 1'b1;
    expect_outs(4'hA, 4'h2, "adapter takeover");
    ADAPTER_SENSE_IN <= 1'b0;
    expect_outs(4'h2, 4'h0, "adapter flag follows");
    $display("test adapter done");
    summarize();
  end
endmodule : tb_pd_sleep_flag_control

// [src/pd_sleep_flag_control.sv]
// Purpose: Switch, supply-ok sink, type 2 flag sink and sleep control of the PD.
// Assumes: Comparator levels and request pins arrive asynchronously on pins.
// Notes: Registers over Avalon-MM; every access answers on the second edge.
`timescale 1ns/1ns
module pd_sleep_flag_control #(
  parameter int SLOW_CYCLES = pd_pkg::SLOW_CYCLES,
  parameter int FAST_CYCLES = pd_pkg::FAST_CYCLES,
  parameter int SIG_ON_CYCLES = pd_pkg::SIG_ON_CYCLES,
  parameter int SIG_OFF_CYCLES = pd_pkg::SIG_OFF_CYCLES,
  parameter int OFF_DELAY_CYCLES = pd_pkg::OFF_DELAY_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic VIN_ABOVE_ON,
  input wire logic VIN_BELOW_OFF,
  input wire logic VIN_BELOW_RESET,
  input wire logic VIN_ABOVE_MARK,
  input wire logic ADAPTER_SENSE_IN,
  input wire logic SWITCH_FULLY_ON,
  input wire logic TYPE2_SEEN,
  input wire logic SLEEP_REQUEST_N,
  input wire logic WAKE_REQUEST_N,
  input wire logic DEEP_SLEEP_SELECT_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic SWITCH_ON,
  output logic SUPPLY_OK_SINK,
  output logic TYPE2_FLAG_SINK,
  output logic INDICATOR_PULSE_OUT,
  output logic SIGNATURE_CURRENT_EN,
  output logic DEEP_SLEEP_ACTIVE
);

  typedef struct packed {
    logic [pd_pkg::IN_W-1:0] s1;
    logic [pd_pkg::IN_W-1:0] s2;
    logic [pd_pkg::IN_W-1:0] s3;
    pd_pkg::mode_t st;
    logic deep;
    logic armed;
    logic type2;
    logic fast;
    logic [pd_pkg::CNT_W-1:0] off_cnt;
    logic [pd_pkg::CNT_W-1:0] sig_cnt;
    logic sig_on;
    logic waitreq;
    logic [31:0] rdata;
    logic sw_on;
    logic sok_sink;
    logic flag_sink;
  } ctl_t;

  ctl_t q, d;
  logic [pd_pkg::IN_W-1:0] pins;
  logic sleep_fall;
  logic wake_fall;
  logic below_reset;
  logic adapter_act;
  logic off_expired;
  logic next_sleep;

  function automatic logic [31:0] read_word(input logic [3:0] addr, input ctl_t c);
    logic [31:0] w;
    w = '0;
    case (addr)
      pd_pkg::CTRL_ADDR: begin
        w[pd_pkg::CTRL_FAST_BIT] = c.fast;
      end
      pd_pkg::STATUS_ADDR: begin
        w[pd_pkg::STATUS_MODE_LSB +: 2] = c.st;
        w[pd_pkg::STATUS_DEEP_BIT] = c.deep;
        w[pd_pkg::STATUS_TYPE2_BIT] = c.type2;
        w[pd_pkg::STATUS_ARMED_BIT] = c.armed;
        w[pd_pkg::STATUS_ADAPTER_BIT] = c.armed && c.s2[pd_pkg::IN_ADAPTER];
        w[pd_pkg::STATUS_SIG_BIT] = c.sig_on;
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction : read_word

  assign pins = {DEEP_SLEEP_SELECT_N, WAKE_REQUEST_N, SLEEP_REQUEST_N, TYPE2_SEEN,
                 SWITCH_FULLY_ON, ADAPTER_SENSE_IN, VIN_ABOVE_MARK, VIN_BELOW_RESET,
                 VIN_BELOW_OFF, VIN_ABOVE_ON};

  // Edge events look only at the second and third stages
  assign sleep_fall = q.s3[pd_pkg::IN_SLEEP_N] && !q.s2[pd_pkg::IN_SLEEP_N];
  assign wake_fall = q.s3[pd_pkg::IN_WAKE_N] && !q.s2[pd_pkg::IN_WAKE_N];
  assign below_reset = q.s2[pd_pkg::IN_BELOW_RESET];
  assign adapter_act = q.armed && q.s2[pd_pkg::IN_ADAPTER];
  assign off_expired = q.s2[pd_pkg::IN_BELOW_OFF]
                       && (q.off_cnt >= pd_pkg::CNT_W'(OFF_DELAY_CYCLES));

  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;

    // Arming and type 2 latch are cleared only by the reset level
    if (below_reset) begin
      d.armed = 1'b0;
      d.type2 = 1'b0;
    end else begin
      if (q.s2[pd_pkg::IN_ABOVE_MARK]) begin
        d.armed = 1'b1;
      end
      if (q.s2[pd_pkg::IN_TYPE2]) begin
        d.type2 = 1'b1;
      end
    end

    // Off delay runs only while the input sits below the turn-off level
    if (q.st != pd_pkg::ST_OFF && q.s2[pd_pkg::IN_BELOW_OFF]) begin
      if (!off_expired) begin
        d.off_cnt = q.off_cnt + 1'b1;
      end
    end else begin
      d.off_cnt = '0;
    end

    case (q.st)
      pd_pkg::ST_OFF: begin
        if (!below_reset && !adapter_act && q.s2[pd_pkg::IN_ABOVE_ON]) begin
          d.st = pd_pkg::ST_INRUSH;
        end
      end
      pd_pkg::ST_INRUSH: begin
        if (q.s2[pd_pkg::IN_FULLY_ON]) begin
          d.st = pd_pkg::ST_POWER;
        end
      end
      pd_pkg::ST_POWER: begin
        if (sleep_fall && !wake_fall) begin
          d.st = pd_pkg::ST_SLEEP;
          d.deep = !q.s2[pd_pkg::IN_DEEP_N];
          d.sig_on = 1'b1;
          d.sig_cnt = '0;
        end
      end
      pd_pkg::ST_SLEEP: begin
        if (wake_fall) begin
          // Wake returns straight to power only if the switch is still fully on
          d.st = q.s2[pd_pkg::IN_FULLY_ON] ? pd_pkg::ST_POWER
                                          : pd_pkg::ST_INRUSH;
        end
      end
      default: begin
        d.st = pd_pkg::ST_OFF;
      end
    endcase

    // Loss of input, reset level or adapter takeover override any request
    if (below_reset || adapter_act || off_expired) begin
      d.st = pd_pkg::ST_OFF;
    end
    if (d.st != pd_pkg::ST_SLEEP) begin
      d.deep = 1'b0;
      d.sig_on = 1'b1;
      d.sig_cnt = '0;
    end else if (q.st == pd_pkg::ST_SLEEP && q.deep) begin
      // Signature current toggles to save power yet keep the source engaged
      if (q.sig_on && q.sig_cnt >= pd_pkg::CNT_W'(SIG_ON_CYCLES - 1)) begin
        d.sig_on = 1'b0;
        d.sig_cnt = '0;
      end else if (!q.sig_on && q.sig_cnt >= pd_pkg::CNT_W'(SIG_OFF_CYCLES - 1)) begin
        d.sig_on = 1'b1;
        d.sig_cnt = '0;
      end else begin
        d.sig_cnt = q.sig_cnt + 1'b1;
      end
    end

    d.sw_on = (d.st != pd_pkg::ST_OFF);
    d.sok_sink = (d.st == pd_pkg::ST_INRUSH)
                 || (d.st == pd_pkg::ST_SLEEP);
    // Adapter term follows the synchronised sense level, so it is never held
    d.flag_sink = (d.st != pd_pkg::ST_SLEEP)
                  && ((d.type2 && d.st == pd_pkg::ST_POWER)
                      || adapter_act);

    // Avalon slave: waitrequest drops for one cycle per request
    d.waitreq = !((AVS_READ || AVS_WRITE) && q.waitreq);
    if (AVS_READ && q.waitreq) begin
      d.rdata = read_word(AVS_ADDRESS, q);
    end
    if (AVS_WRITE && !q.waitreq && AVS_ADDRESS == pd_pkg::CTRL_ADDR && AVS_BYTEENABLE[0]) begin
      d.fast = AVS_WRITEDATA[pd_pkg::CTRL_FAST_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.s1 <= pd_pkg::SYNC_RESET;
      q.s2 <= pd_pkg::SYNC_RESET;
      q.s3 <= pd_pkg::SYNC_RESET;
      q.st <= pd_pkg::ST_OFF;
      q.fast <= pd_pkg::CTRL_FAST_RESET;
      q.sig_on <= 1'b1;
      q.waitreq <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign next_sleep = (d.st == pd_pkg::ST_SLEEP);

  sleep_pulse_gen #(
    .SLOW_CYCLES(SLOW_CYCLES),
    .FAST_CYCLES(FAST_CYCLES)
  ) u_pulse (
    .clk(MCLK),
    .rst_n(RST_N),
    .en(next_sleep),
    .fast(q.fast),
    .pulse(INDICATOR_PULSE_OUT)
  );

  assign AVS_READDATA = q.rdata;
  assign AVS_WAITREQUEST = q.waitreq;
  assign SWITCH_ON = q.sw_on;
  assign SUPPLY_OK_SINK = q.sok_sink;
  assign TYPE2_FLAG_SINK = q.flag_sink;
  assign SIGNATURE_CURRENT_EN = q.sig_on;
  assign DEEP_SLEEP_ACTIVE = q.deep;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  chk_sink_by_mode: assert property (SUPPLY_OK_SINK ==
    (q.st == pd_pkg::ST_INRUSH || q.st == pd_pkg::ST_SLEEP))
    else $error("supply-ok sink disagrees with mode");
  chk_flag_off_sleep: assert property (q.st == pd_pkg::ST_SLEEP |-> !TYPE2_FLAG_SINK)
    else $error("flag sink on during sleep");
  chk_pulse_in_sleep: assert property (INDICATOR_PULSE_OUT |-> q.st == pd_pkg::ST_SLEEP)
    else $error("indicator pulse outside sleep");
  chk_sleep_entry: assert property ((q.st == pd_pkg::ST_POWER && sleep_fall && !wake_fall
    && !below_reset && !adapter_act && !off_expired) |=> q.st == pd_pkg::ST_SLEEP)
    else $error("sleep edge did not enter sleep");
  chk_wake_exit: assert property ((q.st == pd_pkg::ST_SLEEP && wake_fall)
    |=> q.st != pd_pkg::ST_SLEEP) else $error("wake edge ignored");
  chk_wake_priority: assert property ((sleep_fall && wake_fall)
    |=> q.st != pd_pkg::ST_SLEEP) else $error("sleep beat coincident wake");
  chk_deep_select: assert property ((q.st == pd_pkg::ST_POWER && sleep_fall
    && !wake_fall && !below_reset && !adapter_act && !off_expired)
    |=> DEEP_SLEEP_ACTIVE == !$past(q.s2[pd_pkg::IN_DEEP_N]))
    else $error("deep sleep select not honoured");
  chk_deep_in_sleep: assert property (DEEP_SLEEP_ACTIVE |-> q.st == pd_pkg::ST_SLEEP)
    else $error("deep sleep flag outside sleep");
  chk_adapter_off: assert property (adapter_act |=> !SWITCH_ON && TYPE2_FLAG_SINK)
    else $error("adapter did not take over");
  chk_unarmed_sense: assert property (!q.armed |-> !adapter_act)
    else $error("adapter sense used before arming");
  chk_latch_clear: assert property ($fell(q.type2) |-> $past(below_reset))
    else $error("type 2 latch cleared without reset level");
  chk_switch_sleep: assert property (q.st == pd_pkg::ST_SLEEP |-> SWITCH_ON)
    else $error("switch off in sleep");
  chk_sig_on_time: assert property ($rose(q.sig_on) && q.deep |->
    q.sig_cnt == '0) else $error("signature phase did not restart");

  cov_sleep: cover property (q.st == pd_pkg::ST_POWER ##1 q.st == pd_pkg::ST_SLEEP);
  cov_deep: cover property (DEEP_SLEEP_ACTIVE && !SIGNATURE_CURRENT_EN);
  cov_wake: cover property (q.st == pd_pkg::ST_SLEEP ##1 q.st == pd_pkg::ST_POWER);
  cov_adapter: cover property (adapter_act && TYPE2_FLAG_SINK);

endmodule : pd_sleep_flag_control

// [src/sleep_pulse_gen.sv]
// Purpose: Periodic indicator pulse at one quarter duty, two selectable rates.
// Assumes: en is the next-cycle sleep state from the controller.
// Notes: Counter restarts whenever en drops, so each sleep begins with a high phase.
`timescale 1ns/1ns
module sleep_pulse_gen #(
  parameter int SLOW_CYCLES = pd_pkg::SLOW_CYCLES,
  parameter int FAST_CYCLES = pd_pkg::FAST_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic fast,
  output logic pulse
);

  typedef struct packed {
    logic [pd_pkg::CNT_W-1:0] cnt;
    logic pulse;
  } gen_t;

  gen_t q, d;
  logic [pd_pkg::CNT_W-1:0] period;

  always_comb begin
    d = q;
    period = fast ? pd_pkg::CNT_W'(FAST_CYCLES) : pd_pkg::CNT_W'(SLOW_CYCLES);
    if (!en) begin
      d.cnt = '0;
    end else if (q.cnt >= period - 1'b1) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
    d.pulse = en && (d.cnt < (period >> 2));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pulse = q.pulse;

  chk_pulse_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !en |=> !pulse) else $error("pulse ran while disabled");

endmodule : sleep_pulse_gen
